// file: rtl/slot_map_pkg.sv
package slot_map_pkg;
	localparam logic [7:0] CFG_PAGE = 8'h00;
	localparam logic [7:0] THIRD_CH_OFFSET = 8'h0D;
	localparam logic [7:0] FOURTH_CH_OFFSET = 8'h0E;
	localparam logic [7:0] FIFTH_CH_OFFSET = 8'h0F;
	localparam int NUM_CH = 3;
	localparam int SAMPLE_BITS = 32;
	localparam int LINE_SEL_POS = 6;
	localparam int RIGHT_HALF_POS = 5;
	localparam logic [5:0] THIRD_CH_SLOT_RST = 6'h02;
	localparam logic [5:0] FOURTH_CH_SLOT_RST = 6'h03;
	localparam logic [5:0] FIFTH_CH_SLOT_RST = 6'h04;
	localparam logic LINE_SEL_RST = 1'b0;

	typedef enum logic [1:0] {FMT_TDM, FMT_I2S, FMT_LJ} frame_fmt_t;

	// One channel's mapping: which data line, which slot
	typedef struct packed {
		logic lineSel;
		logic [5:0] slotIndex;
	} chan_cfg_t;

	typedef struct packed {
		frame_fmt_t fmt;
		chan_cfg_t [NUM_CH-1:0] chans;
	} link_cfg_t;

	typedef struct packed {
		logic [7:0] page;
		logic [7:0] addr;
		logic wrEn;
		logic [7:0] wrData;
	} reg_req_t;

	localparam link_cfg_t LINK_CFG_RST = '{fmt: FMT_TDM, chans: '{
		'{lineSel: LINE_SEL_RST, slotIndex: FIFTH_CH_SLOT_RST},
		'{lineSel: LINE_SEL_RST, slotIndex: FOURTH_CH_SLOT_RST},
		'{lineSel: LINE_SEL_RST, slotIndex: THIRD_CH_SLOT_RST}}};
endpackage

// file: rtl/audio_port_slot_mapping.sv
`timescale 1ns/1ps
`default_nettype none

module audio_port_slot_mapping (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control-port register access
	input wire slot_map_pkg::reg_req_t regReq,
	output logic [7:0] regRdData,
	// Frame format chosen elsewhere
	input wire slot_map_pkg::frame_fmt_t frameFmt,
	// Serial link, on the bit clock
	input wire logic bitClk,
	input wire logic frameSync,
	input wire logic [slot_map_pkg::SAMPLE_BITS-1:0] chanSample [3],
	output logic primary_serial_out,
	output logic primaryOutEn,
	output logic secondaryOut,
	output logic secondaryOutEn
);
	import slot_map_pkg::*;

	// ---------------- Core domain: registers ----------------
	chan_cfg_t [NUM_CH-1:0] cfg_q;
	logic [7:0] rdData_q;
	wire pageHit = regReq.page == CFG_PAGE;
	wire [NUM_CH-1:0] addrHit;
	wire [7:0] rdMux;

	assign addrHit[0] = pageHit && regReq.addr == THIRD_CH_OFFSET;
	assign addrHit[1] = pageHit && regReq.addr == FOURTH_CH_OFFSET;
	assign addrHit[2] = pageHit && regReq.addr == FIFTH_CH_OFFSET;

	// Bit 7 is never stored, so it cannot read back
	assign rdMux = addrHit[0] ? {1'b0, cfg_q[0]} :
		addrHit[1] ? {1'b0, cfg_q[1]} :
		addrHit[2] ? {1'b0, cfg_q[2]} : 8'h00;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gCfg
			always_ff @(posedge core_clk) begin
				if (rst) begin
					cfg_q[g] <= LINK_CFG_RST.chans[g];
				end else if (regReq.wrEn && addrHit[g]) begin
					cfg_q[g] <= regReq.wrData[6:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdData_q <= 8'h00;
		end else begin
			rdData_q <= rdMux;
		end
	end
	assign regRdData = rdData_q;

	// ---------------- Crossing: toggle handshake ----------------
	// Snapshot only moves while no transfer is open, so the link
	// side always sees a settled word.
	link_cfg_t snap_q;
	logic reqTgl_q;
	logic ackMeta_q, ackSync_q;
	logic reqMeta_q, reqSync_q, reqSeen_q, ackTgl_q;
	logic rstMeta_q, linkRst_q;
	link_cfg_t curCfg;
	wire busy = reqTgl_q != ackSync_q;

	assign curCfg = '{fmt: frameFmt, chans: cfg_q};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			snap_q <= LINK_CFG_RST;
			reqTgl_q <= 1'b0;
			ackMeta_q <= 1'b0;
			ackSync_q <= 1'b0;
		end else begin
			ackMeta_q <= ackTgl_q;
			ackSync_q <= ackMeta_q;
			if (!busy && curCfg != snap_q) begin
				snap_q <= curCfg;
				reqTgl_q <= ~reqTgl_q;
			end
		end
	end

	// ---------------- Link domain ----------------
	link_cfg_t linkCfg_q;
	logic [4:0] bitCnt_q;
	logic [5:0] slotCnt_q;
	logic syncMeta_q, sync_q, syncPrev_q;
	logic priOut_q, priEn_q, secOut_q, secEn_q;
	wire newCfg = reqSync_q != reqSeen_q;
	wire tdm = linkCfg_q.fmt == FMT_TDM;
	wire syncRise = sync_q && !syncPrev_q;
	wire syncEdge = sync_q != syncPrev_q;
	// I2S marks left with a low word clock, left-justified with high
	wire rightHalf = (linkCfg_q.fmt == FMT_I2S) ? sync_q : !sync_q;
	wire frameStart = tdm ? syncRise : syncEdge;
	wire [NUM_CH-1:0] hit, bitVal;
	wire [4:0] bitPos = frameStart ? 5'd0 : bitCnt_q;
	wire [5:0] slotPos = frameStart ? 6'd0 : slotCnt_q;
	wire anyPri, anySec, priBit, secBit;

	generate
		for (g = 0; g < NUM_CH; g++) begin : gHit
			wire [5:0] s = linkCfg_q.chans[g].slotIndex;
			// TDM uses all six bits; halves split on the top bit
			assign hit[g] = tdm ? slotPos == s :
				(s[RIGHT_HALF_POS] == rightHalf &&
				slotPos[4:0] == s[4:0]);
			assign bitVal[g] = chanSample[g][5'(SAMPLE_BITS-1) - bitPos];
		end
	endgenerate

	wire [NUM_CH-1:0] selVec = {linkCfg_q.chans[2].lineSel,
		linkCfg_q.chans[1].lineSel, linkCfg_q.chans[0].lineSel};
	assign anyPri = |(hit & ~selVec);
	assign anySec = |(hit & selVec);
	assign priBit = |(hit & ~selVec & bitVal);
	assign secBit = |(hit & selVec & bitVal);

	// Core reset reaches the bit clock through two flops
	always_ff @(posedge bitClk) begin
		rstMeta_q <= rst;
		linkRst_q <= rstMeta_q;
	end

	always_ff @(posedge bitClk) begin
		if (linkRst_q) begin
			reqMeta_q <= 1'b0;
			reqSync_q <= 1'b0;
			reqSeen_q <= 1'b0;
			ackTgl_q <= 1'b0;
			linkCfg_q <= LINK_CFG_RST;
			syncMeta_q <= 1'b0;
			sync_q <= 1'b0;
			syncPrev_q <= 1'b0;
		end else begin
			reqMeta_q <= reqTgl_q;
			reqSync_q <= reqMeta_q;
			reqSeen_q <= reqSync_q;
			ackTgl_q <= reqSync_q;
			if (newCfg) begin
				linkCfg_q <= snap_q;
			end
			syncMeta_q <= frameSync;
			sync_q <= syncMeta_q;
			syncPrev_q <= sync_q;
		end
	end

	always_ff @(posedge bitClk) begin
		if (linkRst_q) begin
			bitCnt_q <= 5'd0;
			slotCnt_q <= 6'd0;
			priOut_q <= 1'b0;
			priEn_q <= 1'b0;
			secOut_q <= 1'b0;
			secEn_q <= 1'b0;
		end else begin
			bitCnt_q <= bitPos + 5'd1;
			slotCnt_q <= (bitPos == 5'd31) ? slotPos + 6'd1 : slotPos;
			priOut_q <= priBit;
			priEn_q <= anyPri;
			secOut_q <= secBit;
			secEn_q <= anySec;
		end
	end

	assign primary_serial_out = priOut_q;
	assign primaryOutEn = priEn_q;
	assign secondaryOut = secOut_q;
	assign secondaryOutEn = secEn_q;

	// ---------------- Assertions ----------------
	sequence s_rstRelease;
		rst ##1 !rst;
	endsequence

	a_third_ch_reset: assert property (@(posedge core_clk)
		s_rstRelease |-> cfg_q[0] == {LINE_SEL_RST, THIRD_CH_SLOT_RST})
		else $error("third channel reset value wrong");
	a_fourth_ch_reset: assert property (@(posedge core_clk)
		s_rstRelease |-> cfg_q[1] == {LINE_SEL_RST, FOURTH_CH_SLOT_RST})
		else $error("fourth channel reset value wrong");
	a_fifth_ch_reset: assert property (@(posedge core_clk)
		s_rstRelease |-> cfg_q[2] == {LINE_SEL_RST, FIFTH_CH_SLOT_RST})
		else $error("fifth channel reset value wrong");

	sequence s_writeFourth;
		regReq.wrEn && regReq.page == CFG_PAGE &&
			regReq.addr == FOURTH_CH_OFFSET;
	endsequence
	a_fourth_write_read: assert property (@(posedge core_clk)
		disable iff (rst)
		s_writeFourth ##1 (!regReq.wrEn && addrHit[1]) |=>
			regRdData == {1'b0, $past(regReq.wrData[6:0], 2)})
		else $error("fourth channel write did not read back");
	a_reserved_zero: assert property (@(posedge core_clk)
		disable iff (rst) $past(regReq.wrEn && regReq.wrData[7]) |->
			##1 !regRdData[7])
		else $error("reserved bit read as one");

	a_primary_line: assert property (@(posedge bitClk)
		disable iff (linkRst_q)
		(hit[0] && !selVec[0]) |=> primaryOutEn)
		else $error("primary line not driven for its slot");
	a_secondary_line: assert property (@(posedge bitClk)
		disable iff (linkRst_q)
		(hit[1] && selVec[1] && !(|(hit & ~selVec))) |=>
			secondaryOutEn && !primaryOutEn)
		else $error("secondary selection leaked");
	a_left_half: assert property (@(posedge bitClk)
		disable iff (linkRst_q)
		(!tdm && hit[2]) |->
			rightHalf == linkCfg_q.chans[2].slotIndex[RIGHT_HALF_POS])
		else $error("half chosen against slot field");
	a_right_slot: assert property (@(posedge bitClk)
		disable iff (linkRst_q)
		(!tdm && hit[0] && rightHalf) |->
			slotPos == 6'(linkCfg_q.chans[0].slotIndex - 6'd32))
		else $error("right slot index not offset by 32");
	a_tdm_slot: assert property (@(posedge bitClk)
		disable iff (linkRst_q)
		(tdm && hit[1]) |-> slotPos == linkCfg_q.chans[1].slotIndex)
		else $error("TDM slot mismatch");
endmodule

`default_nettype wire

// file: tb/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	// Bit clock from the bench
	input wire logic bitClk,
	// Device data lines
	input wire logic priOut,
	input wire logic priEn,
	input wire logic secOut,
	input wire logic secEn,
	// Frame clock and what was caught
	output logic frameSync,
	output logic [31:0] priWord,
	output logic [31:0] secWord,
	output logic [10:0] priPos,
	output logic [10:0] secPos
);
	logic [10:0] bitPos = 11'h000;
	logic priEnQ = 1'b0;
	logic secEnQ = 1'b0;
	// Half duty, so every framing sees an edge
	assign frameSync = bitPos < 11'h400;
	always @(posedge bitClk) begin
		bitPos <= bitPos + 11'h001;
		priEnQ <= priEn;
		secEnQ <= secEn;
		// Lines are only trusted while driven
		if (priEn) priWord <= {priWord[30:0], priOut};
		if (secEn) secWord <= {secWord[30:0], secOut};
		if (priEn && !priEnQ) priPos <= bitPos;
		if (secEn && !secEnQ) secPos <= bitPos;
	end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import slot_map_pkg::*;
	logic core_clk = 1'b0;
	logic bitClk = 1'b0;
	logic rst = 1'b1;
	reg_req_t regReq = '0;
	frame_fmt_t fmt = FMT_TDM;
	logic [7:0] regRdData;
	logic [31:0] sample [3] = '{32'hA5C30F81, 32'h5B2DE417, 32'h12345678};
	logic priOut, priEn, secOut, secEn, frameSync;
	logic [31:0] priWord, secWord;
	logic [10:0] priPos, secPos;
	int numErrors = 0;
	int nTests = 0;
	always #12.5 core_clk = ~core_clk;
	// Offset keeps the two clocks apart in phase
	initial begin
		#7;
		forever #62.5 bitClk = ~bitClk;
	end
	audio_port_slot_mapping u_audio_port_slot_mapping (.core_clk(core_clk),
		.rst(rst), .regReq(regReq), .regRdData(regRdData),
		.frameFmt(fmt), .bitClk(bitClk), .frameSync(frameSync),
		.chanSample(sample), .primary_serial_out(priOut),
		.primaryOutEn(priEn), .secondaryOut(secOut),
		.secondaryOutEn(secEn));
	host_bus_model u_host_bus_model (.bitClk(bitClk), .priOut(priOut),
		.priEn(priEn), .secOut(secOut), .secEn(secEn),
		.frameSync(frameSync), .priWord(priWord), .secWord(secWord),
		.priPos(priPos), .secPos(secPos));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			numErrors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] pg, input logic [7:0] ad,
		input logic [7:0] d);
		@(negedge core_clk);
		regReq = '{page: pg, addr: ad, wrEn: 1'b1, wrData: d};
		@(negedge core_clk);
		regReq.wrEn = 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		@(negedge core_clk);
		regReq.page = CFG_PAGE;
		regReq.addr = ad;
		@(negedge core_clk);
		check({24'h0, regRdData}, {24'h0, exp});
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", numErrors, nTests);
		if (numErrors == 0 && nTests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic reset_values;
		rd(THIRD_CH_OFFSET, 8'h02);
		rd(FOURTH_CH_OFFSET, 8'h03);
		rd(FIFTH_CH_OFFSET, 8'h04);
	endtask
	task automatic reg_access;
		wr(CFG_PAGE, FOURTH_CH_OFFSET, 8'hC5);
		rd(FOURTH_CH_OFFSET, 8'h45);
		wr(8'h01, FIFTH_CH_OFFSET, 8'h3F);
		rd(FIFTH_CH_OFFSET, 8'h04);
		rd(8'h10, 8'h00);
		wr(CFG_PAGE, THIRD_CH_OFFSET, 8'hFF);
		rd(THIRD_CH_OFFSET, 8'h7F);
	endtask
	// Two frame starts: the span between them runs on the new mapping
	task automatic wait_frames;
		int i;
		int rises;
		logic prev;
		rises = 0;
		prev = frameSync;
		for (i = 0; i < 25000 && rises < 2; i++) begin
			@(negedge core_clk);
			if (frameSync && !prev) begin
				rises++;
			end
			prev = frameSync;
		end
		if (rises < 2) begin
			numErrors++;
			$display("unexpected at %0t: no frame", $time);
			report_and_stop;
		end
	endtask
	// Slot N bit 0 reaches the model three bit clocks after its start
	// Slots 1 and 2 abut on primary; slot 40 alone on secondary
	task automatic link_tdm;
		fmt = FMT_TDM;
		wr(CFG_PAGE, THIRD_CH_OFFSET, 8'h02);
		wr(CFG_PAGE, FOURTH_CH_OFFSET, 8'h68);
		wr(CFG_PAGE, FIFTH_CH_OFFSET, 8'h01);
		wait_frames;
		check(priWord, sample[0]);
		check(32'(priPos), 32'h23);
		check(secWord, sample[1]);
		check(32'(secPos), 32'h503);
	endtask
	// High sync is the right half here; right 1, right 30, left 5
	task automatic link_i2s;
		fmt = FMT_I2S;
		wr(CFG_PAGE, THIRD_CH_OFFSET, 8'h21);
		wr(CFG_PAGE, FOURTH_CH_OFFSET, 8'h45);
		wr(CFG_PAGE, FIFTH_CH_OFFSET, 8'h7E);
		wait_frames;
		check(priWord, sample[0]);
		check(32'(priPos), 32'h23);
		check(secWord, sample[1]);
		check(32'(secPos), 32'h4A3);
	endtask
	// Same mapping, halves swapped: right slots follow the low sync
	task automatic link_lj;
		fmt = FMT_LJ;
		wait_frames;
		check(priWord, sample[0]);
		check(32'(priPos), 32'h423);
		check(secWord, sample[2]);
		check(32'(secPos), 32'h7C3);
	endtask
	initial begin
		// Two link clock edges carry reset over
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		reset_values;
		reg_access;
		link_tdm;
		link_i2s;
		link_lj;
		report_and_stop;
	end
endmodule
`default_nettype wire
